// File: amc_serial.sv
// Constants for the operating mode sequencer, and the serial result shifter.
// Assumes a single pclk domain; the serial clock arrives from an outside host.
package amc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_CHAN = 8'h0C;
  localparam logic [7:0] ADDR_DIAG = 8'h10;
  localparam logic [7:0] ADDR_OFFS0 = 8'h20;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int MODE_LSB = 2;
  localparam int MODE_MSB = 5;
  localparam int REF_EN_BIT = 8;
  localparam int CONT_RD_BIT = 11;
  localparam int OSC_EN_BIT = 12;
  localparam int PSW_EN_BIT = 13;
  localparam int VBIAS_EN_BIT = 14;
  localparam int CLKSEL_EXT_BIT = 1;
  localparam logic [15:0] CTRL_WMASK = 16'h7BFF;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // Mode codes
  localparam logic [3:0] MODE_CONT = 4'h0;
  localparam logic [3:0] MODE_SINGLE = 4'h1;
  localparam logic [3:0] MODE_STBY = 4'h2;
  localparam logic [3:0] MODE_PDOWN = 4'h3;
  localparam logic [3:0] MODE_IDLE = 4'h4;
  localparam logic [3:0] MODE_ZCAL = 4'h5;

  // ----------------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------------
  localparam int RES_W = 24;
  localparam int NCH = 8;
  localparam logic [23:0] DATA_RST = 24'h00_0000;
  localparam logic [23:0] OFFS_RST = 24'h80_0000;
  localparam logic [7:0] CHAN_RST = 8'h01;
  localparam logic [7:0] DIAG_RST = 8'h00;
  localparam int DIAG_CLK_N = 5;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int SETTLE_TIME_NS = 20000;
  localparam int ODR_TIME_NS = 5000;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int ODR_CYC = (ODR_TIME_NS + CLK_NS - 1) / CLK_NS;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETTLE = 6'h02,
    ST_CONV = 6'h04,
    ST_STBY = 6'h08,
    ST_PDOWN = 6'h10,
    ST_CAL = 6'h20
  } amc_state_t;

endpackage

`timescale 1ns/100ps

// Shifts a stored result out on serial clock falling edges (idle high).
module amc_serial #(
  parameter int RES_W = 24
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Serial pins
  input wire logic sclk_pin,
  output logic sdo,
  // Sequencer side
  input wire logic cont_read,
  input wire logic load,
  input wire logic [RES_W-1:0] load_data,
  input wire logic rdy_n,
  output logic read_done
);

  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_d_r;
  logic [RES_W-1:0] shreg_r;
  logic [4:0] bitcnt_r;
  logic busy_r;
  logic out_r;
  logic done_r;
  wire sclk_fall = sclk_d_r & ~sclk_s2_r;
  wire sclk_rise = ~sclk_d_r & sclk_s2_r;
  wire last_bit = bitcnt_r == 5'(RES_W - 1);

  // Two-stage synchroniser, then edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_d_r <= 1'b1;
    end else begin
      sclk_s1_r <= sclk_pin;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r <= sclk_s2_r;
    end
  end

  // Load on each new result while continuous read is set; a fresh result overrides a half-read one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_r <= '0;
      bitcnt_r <= 5'h00;
      busy_r <= 1'b0;
      out_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (load && cont_read) begin
        shreg_r <= load_data;
        bitcnt_r <= 5'h00;
        busy_r <= 1'b1;
        out_r <= 1'b0;
      end else if (busy_r) begin
        if (sclk_fall) begin
          out_r <= shreg_r[RES_W-1];
          shreg_r <= {shreg_r[RES_W-2:0], 1'b0};
        end
        if (sclk_rise) begin
          bitcnt_r <= bitcnt_r + 5'h01;
          busy_r <= ~last_bit;
          done_r <= last_bit;
        end
      end
    end
  end

  // Pin shows ready state between words
  assign sdo = busy_r ? out_r : rdy_n;
  assign read_done = done_r;

endmodule // amc_serial

// File: amc_ctrl.sv
// Operating mode sequencer of a sigma-delta converter with APB registers.
// Assumes filter output adc_sample is synchronous to pclk; sclk is not.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps

// Operation
// - Mode taken from control bits five to two
// - Code 0000 converts continuously into data register
// - Ready goes low per finished conversion
// - Continuous read shifts results out on clocks
// - First result only after full settling time
// - Later results at output data rate
// - Single conversion stores, readies, returns to standby
// - Single result and ready held until read
// - Data register read releases ready high
// - Standby powers down all but regulators
// - Standby allows reference, oscillator, switch, bias control
// - Enabled diagnostics keep running in standby, except clocked ones (bits 4:0), held off
// - Clocked diagnostics enabled in standby stay off
// - Power-down shuts off all circuitry and regulators
// - Power-down loses registers, reads reset values
// - Idle holds filter and modulator in reset
// - Code 0101 shorts input, measures offset
// - Calibration raises ready, lowers it when done
// - Finished calibration switches mode to idle
// - Offset stored for the selected channel
// - Zero-scale calibration lasts one settling period
module amc_ctrl #(
  parameter int SETTLE_CYC = amc_pkg::SETTLE_CYC,
  parameter int ODR_CYC = amc_pkg::ODR_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sclk_pin,
  output logic sdo,
  output logic rdy_n,
  // Filter result
  input wire logic [23:0] adc_sample,
  // Analog power and control
  output logic ldo_en,
  output logic clk_en,
  output logic osc_en,
  output logic ref_en,
  output logic psw_en,
  output logic vbias_en,
  output logic mod_rst,
  output logic mod_clk_en,
  output logic in_short,
  output logic [7:0] diag_run
);

  localparam int SETTLE_M1 = SETTLE_CYC - 1;
  localparam int ODR_M1 = ODR_CYC - 1;
  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
  localparam logic [15:0] ODR_LAST = 16'(ODR_CYC - 1);
  localparam int DCN = amc_pkg::DIAG_CLK_N;

  logic [15:0] ctrl_r;
  logic [7:0] chan_r;
  logic [7:0] diag_r;
  logic [DCN-1:0] arm_r;
  logic [23:0] data_r;
  logic [23:0] offs_r [amc_pkg::NCH];
  logic rdy_n_r;
  logic [31:0] prdata_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  amc_pkg::amc_state_t state_r;
  amc_pkg::amc_state_t st_nxt;
  logic conv_done;
  logic cal_done;
  logic ser_done;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire acc = psel & penable;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire sel_ctrl = paddr == amc_pkg::ADDR_CTRL;
  wire sel_stat = paddr == amc_pkg::ADDR_STATUS;
  wire sel_data = paddr == amc_pkg::ADDR_DATA;
  wire sel_chan = paddr == amc_pkg::ADDR_CHAN;
  wire sel_diag = paddr == amc_pkg::ADDR_DIAG;
  wire sel_offs = (paddr[7:5] == amc_pkg::ADDR_OFFS0[7:5])
                  && (paddr[1:0] == 2'b00);
  wire [2:0] off_idx = paddr[4:2];
  wire mapped = sel_ctrl | sel_stat | sel_data | sel_chan | sel_diag
                | sel_offs;
  wire wr_ctrl = wr_acc & sel_ctrl;
  wire wr_chan = wr_acc & sel_chan;
  wire wr_diag = wr_acc & sel_diag;
  wire wr_offs = wr_acc & sel_offs;
  wire data_read = rd_acc & sel_data;

  // ----------------------------------------------------------------------
  // Mode and derived conditions
  // ----------------------------------------------------------------------
  wire [3:0] mode = ctrl_r[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB];
  wire [3:0] mode_new = wr_ctrl
                        ? pwdata[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB]
                        : mode;
  wire pd = mode == amc_pkg::MODE_PDOWN;
  wire pd_wr = pd | (mode_new == amc_pkg::MODE_PDOWN);
  // Channel or mode writes count as reconfiguration
  wire restart = wr_ctrl | wr_chan;
  wire cal_start = restart & (mode_new == amc_pkg::MODE_ZCAL);
  wire st_conv = (state_r == amc_pkg::ST_SETTLE)
                 | (state_r == amc_pkg::ST_CONV);
  wire mclk_on = st_conv | (state_r == amc_pkg::ST_IDLE)
                 | (state_r == amc_pkg::ST_CAL);
  // Clocked diagnostics arm only in continuous or idle mode
  wire mclk_ok = (st_conv & (mode == amc_pkg::MODE_CONT))
                 | (state_r == amc_pkg::ST_IDLE);
  wire single_end = conv_done & (state_r == amc_pkg::ST_SETTLE)
                    & (mode == amc_pkg::MODE_SINGLE);
  wire [31:0] status_w = {18'h0_0000, state_r, mode, 3'h0, rdy_n_r};

  // Lowest enabled channel; host enables just one for calibration
  function automatic logic [2:0] first_ch(input logic [7:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  wire [2:0] cal_ch = first_ch(chan_r);

  // Entry state of each mode code; reserved codes park in idle
  function automatic amc_pkg::amc_state_t entry_st(input logic [3:0] m);
    amc_pkg::amc_state_t s;
    case (m)
      amc_pkg::MODE_CONT: s = amc_pkg::ST_SETTLE;
      amc_pkg::MODE_SINGLE: s = amc_pkg::ST_SETTLE;
      amc_pkg::MODE_STBY: s = amc_pkg::ST_STBY;
      amc_pkg::MODE_PDOWN: s = amc_pkg::ST_PDOWN;
      amc_pkg::MODE_ZCAL: s = amc_pkg::ST_CAL;
      default: s = amc_pkg::ST_IDLE;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Every (re)entry starts a fresh settling period, never a partial one
  always_comb begin
    st_nxt = state_r;
    cnt_nxt = cnt_r + 16'h0001;
    conv_done = 1'b0;
    cal_done = 1'b0;
    if (restart) begin
      st_nxt = entry_st(mode_new);
      cnt_nxt = 16'h0000;
    end else begin
      case (state_r)
        amc_pkg::ST_SETTLE: begin
          if (cnt_r == SETTLE_LAST) begin
            conv_done = 1'b1;
            cnt_nxt = 16'h0000;
            st_nxt = (mode == amc_pkg::MODE_SINGLE)
                     ? amc_pkg::ST_STBY : amc_pkg::ST_CONV;
          end
        end
        amc_pkg::ST_CONV: begin
          if (cnt_r == ODR_LAST) begin
            conv_done = 1'b1;
            cnt_nxt = 16'h0000;
          end
        end
        amc_pkg::ST_CAL: begin
          if (cnt_r == SETTLE_LAST) begin
            cal_done = 1'b1;
            cnt_nxt = 16'h0000;
            st_nxt = amc_pkg::ST_IDLE;
          end
        end
        default: begin
          cnt_nxt = 16'h0000;
        end
      endcase
    end
  end

  // Reset starts the default continuous mode, settling first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= amc_pkg::ST_SETTLE;
      cnt_r <= 16'h0000;
    end else begin
      state_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Power-down keeps only the mode field, so leaving it shows reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= amc_pkg::CTRL_RST;
    end else if (wr_ctrl && pd_wr) begin
      ctrl_r <= amc_pkg::CTRL_RST;
      ctrl_r[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB] <= mode_new;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[15:0] & amc_pkg::CTRL_WMASK;
    end else if (single_end) begin
      ctrl_r[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB] <= amc_pkg::MODE_STBY;
    end else if (cal_done) begin
      ctrl_r[amc_pkg::MODE_MSB:amc_pkg::MODE_LSB] <= amc_pkg::MODE_IDLE;
    end
  end

  // Channel, diagnostic and result registers; cleared throughout power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_r <= amc_pkg::CHAN_RST;
      diag_r <= amc_pkg::DIAG_RST;
      arm_r <= '0;
      data_r <= amc_pkg::DATA_RST;
    end else if (pd) begin
      chan_r <= amc_pkg::CHAN_RST;
      diag_r <= amc_pkg::DIAG_RST;
      arm_r <= '0;
      data_r <= amc_pkg::DATA_RST;
    end else begin
      if (wr_chan) begin
        chan_r <= pwdata[7:0];
      end
      if (wr_diag) begin
        diag_r <= pwdata[7:0];
        arm_r <= mclk_ok ? pwdata[DCN-1:0] : arm_r & pwdata[DCN-1:0];
      end else if (mclk_ok) begin
        arm_r <= diag_r[DCN-1:0];
      end
      if (conv_done) begin
        data_r <= adc_sample;
      end
    end
  end

  // Offset registers, one per channel
  for (genvar g = 0; g < amc_pkg::NCH; g++) begin : g_offs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        offs_r[g] <= amc_pkg::OFFS_RST;
      end else if (pd) begin
        offs_r[g] <= amc_pkg::OFFS_RST;
      end else if (cal_done && cal_ch == 3'(g)) begin
        offs_r[g] <= adc_sample;
      end else if (wr_offs && off_idx == 3'(g)) begin
        offs_r[g] <= pwdata[23:0];
      end
    end
  end

  // Ready flag: a finishing conversion wins over a read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_n_r <= 1'b1;
    end else if (conv_done || cal_done) begin
      rdy_n_r <= 1'b0;
    end else if (cal_start || pd) begin
      rdy_n_r <= 1'b1;
    end else if (data_read || ser_done) begin
      rdy_n_r <= 1'b1;
    end
  end

  // Read data captured in the setup phase, answered with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= sel_ctrl ? {16'h0000, ctrl_r}
                : sel_stat ? status_w
                : sel_data ? {8'h00, data_r}
                : sel_chan ? {24'h00_0000, chan_r}
                : sel_diag ? {24'h00_0000, diag_r}
                : sel_offs ? {8'h00, offs_r[off_idx]}
                : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------------------------------------
  // Serial result output
  // ----------------------------------------------------------------------
  amc_serial #(
    .RES_W(amc_pkg::RES_W)
  ) u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_pin(sclk_pin),
    .sdo(sdo),
    .cont_read(ctrl_r[amc_pkg::CONT_RD_BIT]),
    .load(conv_done),
    .load_data(adc_sample),
    .rdy_n(rdy_n_r),
    .read_done(ser_done)
  );

  // ----------------------------------------------------------------------
  // Power and analog controls
  // ----------------------------------------------------------------------
  // Standby keeps only regulators plus the software-chosen helpers
  assign ldo_en = ~pd;
  assign osc_en = ~pd & ~ctrl_r[amc_pkg::CLKSEL_EXT_BIT]
                  & (mclk_on | ctrl_r[amc_pkg::OSC_EN_BIT]);
  assign clk_en = ~pd & (mclk_on | ctrl_r[amc_pkg::OSC_EN_BIT]);
  assign ref_en = ctrl_r[amc_pkg::REF_EN_BIT];
  assign psw_en = ctrl_r[amc_pkg::PSW_EN_BIT];
  assign vbias_en = ctrl_r[amc_pkg::VBIAS_EN_BIT];
  assign mod_rst = ~st_conv & (state_r != amc_pkg::ST_CAL);
  assign mod_clk_en = mclk_on;
  assign in_short = state_r == amc_pkg::ST_CAL;
  assign rdy_n = rdy_n_r;
  // Clocked checks need the master clock and arming in a clocked mode
  assign diag_run = {diag_r[7:DCN],
                     diag_r[DCN-1:0] & arm_r & {DCN{mclk_on}}};

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_conv_rdy;
    conv_done |=> !rdy_n_r && data_r == $past(adc_sample);
  endproperty
  a_conv_rdy: assert property (p_conv_rdy)
    else $error("ready or data not updated after conversion");

  property p_rate;
    conv_done && state_r == amc_pkg::ST_CONV |-> cnt_r == 16'(ODR_M1);
  endproperty
  a_rate: assert property (p_rate)
    else $error("conversion not at output data rate");

  property p_settle;
    (conv_done || cal_done) && state_r != amc_pkg::ST_CONV
      |-> cnt_r == 16'(SETTLE_M1);
  endproperty
  a_settle: assert property (p_settle)
    else $error("settling result before full settling time");

  property p_single;
    single_end && !restart |=> state_r == amc_pkg::ST_STBY
      && mode == amc_pkg::MODE_STBY && !rdy_n_r;
  endproperty
  a_single: assert property (p_single)
    else $error("single conversion did not fall back to standby");

  property p_read_clear;
    data_read && !conv_done && !cal_done |=> rdy_n_r;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("data read did not release ready");

  property p_cal_end;
    cal_done && !restart |=> state_r == amc_pkg::ST_IDLE
      && mode == amc_pkg::MODE_IDLE
      && offs_r[$past(cal_ch)] == $past(adc_sample);
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration end did not store offset or go idle");

  property p_cal_start;
    cal_start |=> rdy_n_r && in_short ##SETTLE_CYC (!rdy_n_r || $past(restart));
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration ready sequence wrong");

  property p_pd_state;
    pd && $past(pd) |-> !ldo_en && !clk_en && chan_r == amc_pkg::CHAN_RST
      && offs_r[0] == amc_pkg::OFFS_RST && ctrl_r[15:6] == 10'h000;
  endproperty
  a_pd_state: assert property (p_pd_state)
    else $error("power-down kept power or register contents");

  property p_stby_diag;
    state_r == amc_pkg::ST_STBY |-> diag_run[DCN-1:0] == '0
      && diag_run[7:DCN] == diag_r[7:DCN] && ldo_en;
  endproperty
  a_stby_diag: assert property (p_stby_diag)
    else $error("standby diagnostic gating wrong");

  property p_idle;
    state_r == amc_pkg::ST_IDLE |-> mod_rst && mod_clk_en;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle does not hold modulator in reset with clocks");

  c_single: cover property (single_end);
  c_cal: cover property (cal_done);
  c_serial: cover property (ser_done);
  c_pdown: cover property (pd && wr_ctrl && mode_new != amc_pkg::MODE_PDOWN);

endmodule // amc_ctrl

// File: amc_host.sv
// Host model on the serial side: clocks one 24-bit result out per frame.
// Assumes it is started by a rising start pulse; idle clock high.
`timescale 1ns/100ps

module amc_host (
  // Frame control
  input wire logic start,
  output logic done,
  output logic [23:0] word,
  // Serial pins
  output logic sclk_pin,
  input wire logic sdo
);
  // Clock stands high between frames, so no stray edges reach the shifter
  initial begin
    sclk_pin = 1'b1;
    done = 1'b0;
    word = 24'h00_0000;
  end

  // 800 ns period; data taken on the rising edge, MSB first
  always @(posedge start) begin
    done = 1'b0;
    // Half a pclk of lead keeps pin edges away from pclk rising edges
    #50;
    repeat (24) begin
      #400 sclk_pin = 1'b0;
      #400 sclk_pin = 1'b1;
      word = {word[22:0], sdo};
    end
    done = 1'b1;
  end
endmodule // amc_host

// File: amc_ctrl_tb.sv
// Self-checking bench for the mode sequencer: APB master and filter stub.
// Assumes amc_pkg, amc_serial, amc_ctrl and amc_host compiled first.
`timescale 1ns/100ps

module amc_ctrl_tb;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  localparam int SC = 12;
  localparam int OC = 300;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, sclk_pin, sdo, rdy_n, hdone;
  logic start = 1'b0;
  logic [23:0] adc_sample = 24'h5A_3C96;
  logic [23:0] hword;
  logic ldo_en, clk_en, osc_en, ref_en, psw_en, vbias_en;
  logic mod_rst, mod_clk_en, in_short;
  logic [7:0] diag_run;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  time t0;

  // Clock, 100 ns period
  always #50 pclk = ~pclk;

  amc_ctrl #(.SETTLE_CYC(SC), .ODR_CYC(OC)) amc_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk_pin(sclk_pin), .sdo(sdo),
    .rdy_n(rdy_n), .adc_sample(adc_sample), .ldo_en(ldo_en),
    .clk_en(clk_en), .osc_en(osc_en), .ref_en(ref_en), .psw_en(psw_en),
    .vbias_en(vbias_en), .mod_rst(mod_rst), .mod_clk_en(mod_clk_en),
    .in_short(in_short), .diag_run(diag_run));
  amc_host amc_host_i (.start(start), .done(hdone), .word(hword),
    .sclk_pin(sclk_pin), .sdo(sdo));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts settled edges until ready falls, bounded
  task automatic wait_rdy();
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (rdy_n !== 1'b0 && n < 2000);
  endtask

  task automatic step();
    @(posedge pclk);
    #1;
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk({31'h0, rdy_n}, 32'h1);
    chk({30'h0, pready, pslverr}, 32'h2);
    apb(1'b0, amc_pkg::ADDR_DATA, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, amc_pkg::ADDR_CHAN, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, amc_pkg::ADDR_OFFS0, 32'h0);
    chk(rd, 32'h0080_0000);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, se}, 32'h1);
  endtask

  // Restart, settle time, then output rate and ready release
  task automatic t_cont();
    wait_rdy();
    apb(1'b0, amc_pkg::ADDR_DATA, 32'h0);
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0000);
    wait_rdy();
    chk(32'(n), 32'(SC));
    t0 = $time;
    apb(1'b0, amc_pkg::ADDR_DATA, 32'h0);
    chk(rd, {8'h00, adc_sample});
    step();
    chk({31'h0, rdy_n}, 32'h1);
    wait_rdy();
    chk(32'(($time - t0) / 100), 32'(OC));
  endtask

  task automatic t_serial();
    @(posedge pclk);
    adc_sample <= 24'hC3_A55A;
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0800);
    // Release the old result so ready falls only with the loaded word
    apb(1'b0, amc_pkg::ADDR_DATA, 32'h0);
    wait_rdy();
    @(posedge pclk);
    start <= 1'b1;
    n = 0;
    while (hdone !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    start <= 1'b0;
    chk({8'h00, hword}, 32'h00C3_A55A);
    repeat (8) step();
    chk({31'h0, rdy_n}, 32'h1);
  endtask

  task automatic t_single();
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0004);
    wait_rdy();
    chk(32'(n), 32'(SC));
    apb(1'b0, amc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0008);
    apb(1'b0, amc_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0820);
    repeat (400) step();
    chk({31'h0, rdy_n}, 32'h0);
    apb(1'b0, amc_pkg::ADDR_DATA, 32'h0);
    chk(rd, 32'h00C3_A55A);
  endtask

  task automatic t_zcal();
    @(posedge pclk);
    adc_sample <= 24'h01_0203;
    apb(1'b1, amc_pkg::ADDR_CHAN, 32'h0000_0004);
    // A single result first, so the calibration start must raise ready
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0004);
    wait_rdy();
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0014);
    step();
    chk({30'h0, rdy_n, in_short}, 32'h3);
    wait_rdy();
    chk({31'h0, n <= SC + 1}, 32'h1);
    apb(1'b0, amc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b0, amc_pkg::ADDR_OFFS0 + 8'h08, 32'h0);
    chk(rd, 32'h0001_0203);
    chk({30'h0, mod_rst, mod_clk_en}, 32'h3);
  endtask

  // Abandoned single, standby controls, diagnostics, power-down loss
  task automatic t_power();
    apb(1'b0, amc_pkg::ADDR_DATA, 32'h0);
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0004);
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_7108);
    repeat (SC + 8) step();
    chk({31'h0, rdy_n}, 32'h1);
    chk({26'h0, ldo_en, mod_rst, ref_en, psw_en, vbias_en, osc_en},
        32'h3F);
    apb(1'b1, amc_pkg::ADDR_DIAG, 32'h0000_00FF);
    step();
    chk({24'h0, diag_run}, 32'h0000_00E0);
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_000C);
    step();
    chk({26'h0, ldo_en, clk_en, psw_en, vbias_en, ref_en, mod_clk_en},
        32'h0);
    apb(1'b0, amc_pkg::ADDR_CHAN, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, amc_pkg::ADDR_OFFS0 + 8'h08, 32'h0);
    chk(rd, 32'h0080_0000);
    apb(1'b1, amc_pkg::ADDR_CTRL, 32'h0000_0010);
    apb(1'b0, amc_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0010);
  endtask

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cont();
    t_serial();
    t_single();
    t_zcal();
    t_power();
    report_and_stop();
  end

  // Run needs about 1100 cycles; allow about nine times that
  initial begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end
endmodule // amc_ctrl_tb
